// File: verif/trcb_pins_model.sv
`timescale 1ns/1ns
// ****************************************************************
// Pin driver and serial port observer
// ****************************************************************
module trcb_pins_model
    import trcb_pkg::*;
(
    input wire logic clk_sys,
    input wire trcb_baud_t baud,
    output logic count_input_pin,
    output logic ext_trigger_pin
);
    int since;
    int gap;
    int bad_width;
    logic prev;

    // Pins idle high
    initial begin
        count_input_pin = 1'b1;
        ext_trigger_pin = 1'b1;
        since = 0;
        gap = 0;
        bad_width = 0;
        prev = 1'b0;
    end

    // Measure baud pulse spacing and width
    always @(posedge clk_sys) begin
        since <= since + 1;
        prev <= baud.ovf_pulse;
        if (baud.ovf_pulse && prev) begin
            bad_width <= bad_width + 1;
        end
        if (baud.ovf_pulse && !prev) begin
            gap <= since;
            since <= 1;
        end
    end

    // Falling edge on chosen pins, levels held three clocks each
    task automatic fall(input logic c, input logic t);
        @(posedge clk_sys);
        if (c) count_input_pin <= 1'b0;
        if (t) ext_trigger_pin <= 1'b0;
        repeat (3) @(posedge clk_sys);
        if (c) count_input_pin <= 1'b1;
        if (t) ext_trigger_pin <= 1'b1;
        repeat (3) @(posedge clk_sys);
    endtask

    // Direction level on the trigger pin
    task automatic set_dir(input logic lvl);
        @(posedge clk_sys);
        ext_trigger_pin <= lvl;
        repeat (4) @(posedge clk_sys);
    endtask
endmodule

// File: verif/trcb_timer_test.sv
`timescale 1ns/1ns
`define TRCB_CHK(got, exp) begin checked++; if ((got) !== (exp)) begin err_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
// ****************************************************************
// Self-checking bench
// ****************************************************************
module trcb_timer_test
    import trcb_pkg::*;
;
    logic clk_sys;
    logic rst;
    trcb_bus_t bus;
    logic [7:0] rdata;
    logic count_input_pin;
    logic ext_trigger_pin;
    logic irq_req;
    trcb_baud_t baud;
    int err_count;
    int checked;
    int cycles;
    logic [3:0] a;

    trcb_timer #(.TIMER_DIVIDE(12), .BAUD_DIVIDE(2)) DUT (
        .clk_sys(clk_sys),
        .rst(rst),
        .bus(bus),
        .rdata(rdata),
        .count_input_pin(count_input_pin),
        .ext_trigger_pin(ext_trigger_pin),
        .irq_req(irq_req),
        .baud(baud)
    );

    trcb_pins_model pins (
        .clk_sys(clk_sys),
        .baud(baud),
        .count_input_pin(count_input_pin),
        .ext_trigger_pin(ext_trigger_pin)
    );

    // Clock at 100 MHz
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Hang guard
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        if (err_count == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // One-cycle write strobe
    task automatic wr(input logic [3:0] ad, input logic [7:0] d);
        @(posedge clk_sys);
        bus <= '{addr: ad, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        bus.wr <= 1'b0;
    endtask

    // One-cycle read strobe, data compared in the following cycle
    task automatic rd(input logic [3:0] ad, input logic [7:0] e);
        @(posedge clk_sys);
        bus <= '{addr: ad, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        bus.rd <= 1'b0;
        #1;
        `TRCB_CHK(rdata, e)
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // Main sequence
    initial begin
        rst = 1'b1;
        bus = '0;
        err_count = 0;
        checked = 0;
        cycles = 0;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        // All registers clear, unmapped place reads zero
        for (int i = 0; i <= 8; i++) begin
            a = 4'(i);
            rd(a, 8'h00);
        end
        // Trigger reload with run clear, then timer rate
        wr(OFF_RELOAD_LOW, 8'hF0);
        wr(OFF_RELOAD_HIGH, 8'hFF);
        wr(OFF_CONTROL, 8'h08);
        pins.fall(1'b0, 1'b1);
        rd(OFF_COUNT_LOW, 8'hF0);
        rd(OFF_CONTROL, 8'h48);
        `TRCB_CHK(irq_req, 1'b1)
        wr(OFF_CONTROL, 8'h0C);
        #1;
        `TRCB_CHK(irq_req, 1'b0)
        idle(64);
        wr(OFF_CONTROL, 8'h08);
        idle(30);
        rd(OFF_COUNT_LOW, 8'hF5);
        // Overflow reloads and sets flag
        wr(OFF_CONTROL, 8'h0C);
        idle(150);
        rd(OFF_CONTROL, 8'h8C);
        `TRCB_CHK(irq_req, 1'b1)
        rd(OFF_COUNT_HIGH, 8'hFF);
        // Disable halts counting
        wr(OFF_CONTROL, 8'h08);
        pins.fall(1'b0, 1'b1);
        wr(OFF_CONTROL, 8'h0C);
        wr(OFF_DIS_CONTROL, 8'h02);
        rd(OFF_DIS_STATUS, 8'h02);
        rd(OFF_DIS_CONTROL, 8'h02);
        idle(100);
        rd(OFF_COUNT_LOW, 8'hF0);
        wr(OFF_DIS_CONTROL, 8'h00);
        rd(OFF_DIS_STATUS, 8'h00);
        // Baud mode; count registers left alone here
        wr(OFF_CONTROL, 8'h35);
        idle(120);
        `TRCB_CHK(pins.gap, 32)
        `TRCB_CHK(pins.bad_width, 0)
        `TRCB_CHK(baud.transmit_clock_select, 1'b1)
        `TRCB_CHK(baud.receive_clock_select, 1'b1)
        rd(OFF_CONTROL, 8'h35);
        `TRCB_CHK(irq_req, 1'b0)
        wr(OFF_CONTROL, 8'h3C);
        pins.fall(1'b0, 1'b1);
        rd(OFF_CONTROL, 8'h7C);
        `TRCB_CHK(irq_req, 1'b1)
        // Counter mode, trigger and count edge together
        wr(OFF_CONTROL, 8'h00);
        wr(OFF_RELOAD_LOW, 8'h34);
        wr(OFF_RELOAD_HIGH, 8'h12);
        wr(OFF_CONTROL, 8'h0E);
        pins.fall(1'b1, 1'b1);
        rd(OFF_COUNT_LOW, 8'h34);
        for (int i = 0; i < 5; i++) pins.fall(1'b1, 1'b0);
        rd(OFF_COUNT_LOW, 8'h39);
        rd(OFF_COUNT_HIGH, 8'h12);
        // Capture mode copies count
        wr(OFF_RELOAD_LOW, 8'h00);
        wr(OFF_RELOAD_HIGH, 8'h00);
        wr(OFF_CONTROL, 8'h0B);
        pins.fall(1'b0, 1'b1);
        rd(OFF_RELOAD_LOW, 8'h39);
        rd(OFF_RELOAD_HIGH, 8'h12);
        rd(OFF_CONTROL, 8'h4B);
        `TRCB_CHK(irq_req, 1'b1)
        // Up/down: underflow at reload value, then overflow
        wr(OFF_MODE, 8'h01);
        rd(OFF_MODE, 8'h01);
        pins.set_dir(1'b0);
        wr(OFF_CONTROL, 8'h06);
        pins.fall(1'b1, 1'b0);
        rd(OFF_COUNT_LOW, 8'hFF);
        rd(OFF_COUNT_HIGH, 8'hFF);
        rd(OFF_CONTROL, 8'hC6);
        wr(OFF_CONTROL, 8'h46);
        idle(2);
        `TRCB_CHK(irq_req, 1'b0)
        pins.set_dir(1'b1);
        pins.fall(1'b1, 1'b0);
        rd(OFF_COUNT_HIGH, 8'h12);
        rd(OFF_COUNT_LOW, 8'h39);
        rd(OFF_CONTROL, 8'h86);
        `TRCB_CHK(irq_req, 1'b1)
        give_verdict();
    end
endmodule

// File: verilog/trcb_pkg.sv
package trcb_pkg;

    // ****************************************************************
    // Register map (byte-wide registers on a plain port)
    // ****************************************************************
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] OFF_CONTROL = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_MODE = 4'h1;
    localparam logic [ADDR_W-1:0] OFF_RELOAD_LOW = 4'h2;
    localparam logic [ADDR_W-1:0] OFF_RELOAD_HIGH = 4'h3;
    localparam logic [ADDR_W-1:0] OFF_COUNT_LOW = 4'h4;
    localparam logic [ADDR_W-1:0] OFF_COUNT_HIGH = 4'h5;
    localparam logic [ADDR_W-1:0] OFF_DIS_CONTROL = 4'h6;
    localparam logic [ADDR_W-1:0] OFF_DIS_STATUS = 4'h7;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int BIT_CAPTURE_RELOAD_SELECT = 0;
    localparam int BIT_COUNTER_TIMER_SELECT = 1;
    localparam int BIT_RUN_CONTROL = 2;
    localparam int BIT_EXTERNAL_ENABLE = 3;
    localparam int BIT_TRANSMIT_CLOCK_SELECT = 4;
    localparam int BIT_RECEIVE_CLOCK_SELECT = 5;
    localparam int BIT_EXTERNAL_FLAG = 6;
    localparam int BIT_OVERFLOW_FLAG = 7;
    localparam int BIT_UPDOWN_ENABLE = 0;
    localparam int BIT_TIMER_DISABLE = 1;

    // ****************************************************************
    // Reset values and timing
    // ****************************************************************
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [15:0] RST_RELOAD = 16'h0000;
    localparam logic [15:0] RST_COUNT = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam logic [15:0] CAPTURE_RELOAD = 16'h0000;
    localparam int TIMER_DIV = 12;
    localparam int BAUD_DIV = 2;
    localparam int PRESC_W = 4;

    // Register port request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } trcb_bus_t;

    // Outputs towards the serial port
    typedef struct packed {
        logic ovf_pulse;
        logic transmit_clock_select;
        logic receive_clock_select;
    } trcb_baud_t;

    // Whole module state
    typedef struct packed {
        logic [7:0] ctrl;
        logic updown;
        logic [15:0] reload;
        logic [15:0] cnt;
        logic [PRESC_W-1:0] presc;
        logic [2:0] cin_sync;
        logic [2:0] trg_sync;
        logic dis_req;
        logic dis_st;
        logic [7:0] rdata;
        logic baud_pulse;
    } trcb_state_t;

endpackage

// File: verilog/trcb_timer.sv
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/1ns
module trcb_timer
    import trcb_pkg::*;
#(
    parameter int TIMER_DIVIDE = TIMER_DIV,
    parameter int BAUD_DIVIDE = BAUD_DIV
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire trcb_bus_t bus,
    output logic [7:0] rdata,
    input wire logic count_input_pin,
    input wire logic ext_trigger_pin,
    output logic irq_req,
    output trcb_baud_t baud
);

    localparam logic [PRESC_W-1:0] TIMER_LAST = PRESC_W'(TIMER_DIVIDE - 1);
    localparam logic [PRESC_W-1:0] BAUD_LAST = PRESC_W'(BAUD_DIVIDE - 1);

    trcb_state_t s_q;
    trcb_state_t s_d;

    // ****************************************************************
    // Mode decode and events
    // ****************************************************************
    logic baud_mode;
    logic updown_mode;
    logic capture_mode;
    logic disabled;
    logic running;
    logic presc_tick;
    logic cin_fall;
    logic trg_fall;
    logic count_ev;
    logic ext_ev;
    logic dir_up;
    logic at_max;
    logic at_reload;
    logic [15:0] cnt_inc;
    logic ctrl_wr;

    // Baud mode overrides the capture select
    assign baud_mode = s_q.ctrl[BIT_TRANSMIT_CLOCK_SELECT] | s_q.ctrl[BIT_RECEIVE_CLOCK_SELECT];
    assign updown_mode = s_q.updown & ~baud_mode;
    assign capture_mode = s_q.ctrl[BIT_CAPTURE_RELOAD_SELECT] & s_q.ctrl[BIT_EXTERNAL_ENABLE]
        & ~baud_mode & ~s_q.updown;
    assign disabled = s_q.dis_req | s_q.dis_st;
    assign running = s_q.ctrl[BIT_RUN_CONTROL] & ~disabled;

    // Prescaler wrap point picks the count rate
    assign presc_tick = s_q.presc == (baud_mode ? BAUD_LAST : TIMER_LAST);
    // Edges seen on the synchronised samples, never on the first stage
    assign cin_fall = s_q.cin_sync[2] & ~s_q.cin_sync[1];
    assign trg_fall = s_q.trg_sync[2] & ~s_q.trg_sync[1];
    assign count_ev = running
        & (s_q.ctrl[BIT_COUNTER_TIMER_SELECT] ? cin_fall : presc_tick);
    assign ext_ev = s_q.ctrl[BIT_EXTERNAL_ENABLE] & trg_fall & ~disabled & ~updown_mode;
    // Direction follows the synchronised trigger pin level
    assign dir_up = ~updown_mode | s_q.trg_sync[1];
    assign at_max = s_q.cnt == COUNT_MAX;
    assign at_reload = s_q.cnt == s_q.reload;
    assign cnt_inc = s_q.cnt + 16'h0001;
    assign ctrl_wr = bus.wr && bus.addr == OFF_CONTROL;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        logic ovf_set;
        logic ext_set;
        logic ext_tog;
        logic [15:0] cap_next;
        s_d = s_q;
        ovf_set = 1'b0;
        ext_set = 1'b0;
        ext_tog = 1'b0;
        cap_next = s_q.cnt;
        s_d.baud_pulse = 1'b0;

        // Synchronisers: two flops, then one history stage
        s_d.cin_sync = {s_q.cin_sync[1:0], count_input_pin};
        s_d.trg_sync = {s_q.trg_sync[1:0], ext_trigger_pin};

        // Prescaler runs only while counting, restarts when stopped
        if (running && !presc_tick) begin
            s_d.presc = s_q.presc + PRESC_W'(1);
        end else begin
            s_d.presc = '0;
        end

        // Register writes
        if (bus.wr) begin
            case (bus.addr)
                OFF_CONTROL: begin
                    s_d.ctrl = bus.wdata;
                end
                OFF_MODE: begin
                    s_d.updown = bus.wdata[BIT_UPDOWN_ENABLE];
                end
                OFF_RELOAD_LOW: begin
                    s_d.reload[7:0] = bus.wdata;
                end
                OFF_RELOAD_HIGH: begin
                    s_d.reload[15:8] = bus.wdata;
                end
                OFF_DIS_CONTROL: begin
                    s_d.dis_req = bus.wdata[BIT_TIMER_DISABLE];
                end
                default: begin
                end
            endcase
        end

        // Status follows the request once the gate has acted
        s_d.dis_st = s_q.dis_req;

        // Counting per mode
        if (baud_mode) begin
            if (count_ev) begin
                if (at_max) begin
                    s_d.cnt = s_q.reload;
                    s_d.baud_pulse = 1'b1;
                end else begin
                    s_d.cnt = cnt_inc;
                end
            end
            ext_set = ext_ev;
        end else if (capture_mode) begin
            if (count_ev) begin
                cap_next = at_max ? CAPTURE_RELOAD : cnt_inc;
                ovf_set = at_max;
            end
            s_d.cnt = cap_next;
            if (ext_ev) begin
                s_d.reload = cap_next;
                ext_set = 1'b1;
            end
        end else if (updown_mode) begin
            if (count_ev) begin
                if (dir_up) begin
                    if (at_max) begin
                        s_d.cnt = s_q.reload;
                        ovf_set = 1'b1;
                        ext_tog = 1'b1;
                    end else begin
                        s_d.cnt = cnt_inc;
                    end
                end else if (at_reload) begin
                    s_d.cnt = COUNT_MAX;
                    ovf_set = 1'b1;
                    ext_tog = 1'b1;
                end else begin
                    s_d.cnt = s_q.cnt - 16'h0001;
                end
            end
        end else begin
            if (ext_ev) begin
                s_d.cnt = s_q.reload;
                ext_set = 1'b1;
            end else if (count_ev) begin
                if (at_max) begin
                    s_d.cnt = s_q.reload;
                    ovf_set = 1'b1;
                end else begin
                    s_d.cnt = cnt_inc;
                end
            end
        end

        // Hardware set wins over a software clear in the same cycle
        if (ovf_set) begin
            s_d.ctrl[BIT_OVERFLOW_FLAG] = 1'b1;
        end
        if (ext_set) begin
            s_d.ctrl[BIT_EXTERNAL_FLAG] = 1'b1;
        end
        if (ext_tog) begin
            s_d.ctrl[BIT_EXTERNAL_FLAG] = ~s_d.ctrl[BIT_EXTERNAL_FLAG];
        end

        // Read data, valid the cycle after the strobe only
        s_d.rdata = 8'h00;
        if (bus.rd) begin
            case (bus.addr)
                OFF_CONTROL: s_d.rdata = s_q.ctrl;
                OFF_MODE: s_d.rdata = {7'h00, s_q.updown};
                OFF_RELOAD_LOW: s_d.rdata = s_q.reload[7:0];
                OFF_RELOAD_HIGH: s_d.rdata = s_q.reload[15:8];
                OFF_COUNT_LOW: s_d.rdata = s_q.cnt[7:0];
                OFF_COUNT_HIGH: s_d.rdata = s_q.cnt[15:8];
                OFF_DIS_CONTROL: s_d.rdata = {6'h00, s_q.dis_req, 1'b0};
                OFF_DIS_STATUS: s_d.rdata = {6'h00, s_q.dis_st, 1'b0};
                default: s_d.rdata = 8'h00;
            endcase
        end
    end

    // State register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_q <= '{ctrl: RST_CONTROL, updown: 1'b0, reload: RST_RELOAD, cnt: RST_COUNT,
                default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Interrupt: overflow flag outside baud, external flag outside up/down
    assign irq_req = (s_q.ctrl[BIT_OVERFLOW_FLAG] & ~baud_mode)
        | (s_q.ctrl[BIT_EXTERNAL_FLAG] & ~updown_mode);
    assign rdata = s_q.rdata;
    assign baud = '{ovf_pulse: s_q.baud_pulse,
        transmit_clock_select: s_q.ctrl[BIT_TRANSMIT_CLOCK_SELECT],
        receive_clock_select: s_q.ctrl[BIT_RECEIVE_CLOCK_SELECT]};

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    logic auto_up;
    assign auto_up = ~baud_mode & ~capture_mode & ~updown_mode;

    sequence ovf_event_s;
        auto_up && count_ev && at_max && !ext_ev && !bus.wr;
    endsequence

    chk_ovf_reload_flag: assert property (
        ovf_event_s |=> s_q.cnt == $past(s_q.reload) && s_q.ctrl[BIT_OVERFLOW_FLAG] && irq_req)
        else $error("overflow did not reload and flag");

    chk_ext_reload_first: assert property (
        auto_up && ext_ev && !bus.wr |=> s_q.cnt == $past(s_q.reload)
            && s_q.ctrl[BIT_EXTERNAL_FLAG])
        else $error("trigger reload lost or count applied");

    chk_ovf_flag_sticky: assert property (
        s_q.ctrl[BIT_OVERFLOW_FLAG] && !ctrl_wr |=> s_q.ctrl[BIT_OVERFLOW_FLAG])
        else $error("overflow flag cleared by hardware");

    chk_down_underflow: assert property (
        updown_mode && count_ev && !dir_up && at_reload && !bus.wr
            |=> s_q.cnt == COUNT_MAX && s_q.ctrl[BIT_OVERFLOW_FLAG])
        else $error("underflow did not load all ones");

    chk_ext_toggle: assert property (
        updown_mode && count_ev && ((dir_up && at_max) || (!dir_up && at_reload)) && !ctrl_wr
            |=> s_q.ctrl[BIT_EXTERNAL_FLAG] != $past(s_q.ctrl[BIT_EXTERNAL_FLAG]))
        else $error("external flag did not toggle");

    chk_capture_value: assert property (
        capture_mode && ext_ev && !bus.wr |=> s_q.reload == s_q.cnt
            && s_q.ctrl[BIT_EXTERNAL_FLAG])
        else $error("capture did not take the updated count");

    sequence baud_wrap_s;
        baud_mode && count_ev && at_max;
    endsequence

    chk_baud_pulse_one: assert property (
        baud_wrap_s ##1 (!bus.wr || bus.addr != OFF_CONTROL) |-> baud.ovf_pulse ##1 !baud.ovf_pulse)
        else $error("baud pulse not exactly one cycle");

    chk_baud_no_flag: assert property (
        baud_wrap_s and (!s_q.ctrl[BIT_OVERFLOW_FLAG] && !ctrl_wr)
            |=> !s_q.ctrl[BIT_OVERFLOW_FLAG])
        else $error("baud overflow set the overflow flag");

    chk_timer_rate: assert property (
        count_ev && !s_q.ctrl[BIT_COUNTER_TIMER_SELECT] |->
            $past(running, 1) && $past(s_q.presc) == s_q.presc - PRESC_W'(1))
        else $error("timer count rate wrong");

    chk_counter_edge: assert property (
        count_ev && s_q.ctrl[BIT_COUNTER_TIMER_SELECT] |-> $past(count_input_pin, 3)
            && !$past(count_input_pin, 2))
        else $error("count without high then low sample");

    chk_disable_halt: assert property (
        s_q.dis_req && !bus.wr |=> s_q.dis_st ##0 (!running)[*2])
        else $error("disable did not halt or show status");

    chk_ext_flag_irq: assert property (
        auto_up && ext_ev && !bus.wr |=> s_q.ctrl[BIT_EXTERNAL_FLAG] && irq_req)
        else $error("trigger reload did not flag or interrupt");

    chk_timer_step: assert property (
        auto_up && count_ev && !ext_ev && !at_max && !bus.wr
            |=> s_q.cnt == $past(s_q.cnt) + 16'h0001)
        else $error("count did not step by one");

    chk_up_overflow: assert property (
        updown_mode && count_ev && s_q.trg_sync[1] && at_max && !bus.wr
            |=> s_q.cnt == $past(s_q.reload) && s_q.ctrl[BIT_OVERFLOW_FLAG])
        else $error("up overflow did not reload and flag");

    chk_down_step: assert property (
        updown_mode && count_ev && !s_q.trg_sync[1] && !at_reload && !bus.wr
            |=> s_q.cnt == $past(s_q.cnt) - 16'h0001)
        else $error("down count did not step by one");

    chk_updown_no_irq: assert property (
        updown_mode && !s_q.ctrl[BIT_OVERFLOW_FLAG] |-> !irq_req)
        else $error("external flag raised an interrupt in up/down mode");

    chk_capture_wrap: assert property (
        capture_mode && count_ev && at_max && !bus.wr
            |=> s_q.cnt == CAPTURE_RELOAD && s_q.ctrl[BIT_OVERFLOW_FLAG] && irq_req)
        else $error("capture overflow did not reload zero and flag");

    chk_capture_irq: assert property (
        capture_mode && ext_ev && !bus.wr |=> irq_req)
        else $error("capture flag raised no interrupt");

    chk_baud_ext_flag: assert property (
        baud_mode && ext_ev && !bus.wr |=> s_q.ctrl[BIT_EXTERNAL_FLAG] && irq_req)
        else $error("baud trigger edge did not flag");

    chk_pulse_baud_only: assert property (
        baud.ovf_pulse |-> $past(baud_mode) && $past(count_ev))
        else $error("overflow pulse outside a baud wrap");

    chk_stopped_holds: assert property (
        !running && !ext_ev |=> s_q.cnt == $past(s_q.cnt))
        else $error("count moved while stopped");

    chk_disable_write: assert property (
        bus.wr && bus.addr == OFF_DIS_CONTROL
            |=> s_q.dis_req == $past(bus.wdata[BIT_TIMER_DISABLE]))
        else $error("disable request not taken");

    chk_count_read: assert property (
        bus.rd && bus.addr == OFF_COUNT_HIGH |=> rdata == $past(s_q.cnt[15:8]))
        else $error("count high byte read wrong");

    chk_read_idle: assert property (
        !bus.rd |=> rdata == 8'h00)
        else $error("read data stood beyond one cycle");

    chk_trigger_edge: assert property (
        ext_ev |-> $past(ext_trigger_pin, 3) && !$past(ext_trigger_pin, 2))
        else $error("trigger event without high then low sample");

    chk_baud_no_capture: assert property (
        baud_mode && ext_ev && !bus.wr |=> s_q.reload == $past(s_q.reload))
        else $error("baud mode captured on a trigger edge");

endmodule
